// *** tmc_mode_ctrl.v ***
// Mode control of a low-frequency FSK transceiver: state decode, block enables,
// clock generator control, FSK phase accumulator and an AXI4-Lite register slave.
// Assumes pins arrive asynchronously to aclk and that the AXI master shares aclk.
`timescale 1ns/1ns
`include "tmc_map.vh"
module tmc_mode_ctrl #(
   parameter CFG_W = 8,
   parameter [4:0] PLL_MULT_A = `TMC_PLL_MULT_A,
   parameter [4:0] PLL_MULT_B = `TMC_PLL_MULT_B,
   parameter [31:0] INC_MARK = `TMC_INC_MARK,
   parameter [31:0] INC_SPACE = `TMC_INC_SPACE
) (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // AXI4-Lite write address
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   // AXI4-Lite write data
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   // AXI4-Lite write response
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   // AXI4-Lite read address
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   // AXI4-Lite read data
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   // Device pins
   input wire rx_request_pin,
   input wire crystal_input_pin,
   input wire tx_data_pin,
   input wire serial_enable_pin,
   input wire serial_data_pin,
   input wire serial_clock_pin,
   // Block enables
   output reg rx_enable,
   output reg tx_enable,
   output reg carrier_enable,
   output reg pll_enable,
   output reg bias_enable,
   // Clock generator control
   output reg osc_enable,
   output reg ext_clock_select,
   output reg [4:0] pll_mult,
   output reg ref_present,
   // Transmit path
   output reg [2:0] pa_level,
   output reg fsk_mark,
   output reg tx_wave,
   // State
   output reg [1:0] state
);

   // ==================================================
   // Declarations
   reg [2:0] p1;
   reg [2:0] p2;
   reg [2:0] p3;
   reg [2:0] pfilt;
   reg [CFG_W-1:0] settings;
   reg [1:0] next_state;
   reg [31:0] phase;
   reg [15:0] ref_count;
   reg aw_held;
   reg w_held;
   reg [3:0] aw_addr;
   reg [31:0] w_data;
   reg [3:0] w_strb;
   wire [2:0] pagree;
   wire [2:0] next_pfilt;
   wire ref_rise;
   wire rx_req;
   wire tx_bit;
   wire ser_valid;
   wire [CFG_W-1:0] ser_word;
   wire ser_bad;
   wire do_write;
   wire [31:0] status_word;

   // Decode a register offset into a read value
   function [31:0] read_mux;
      input [3:0] addr;
      input [CFG_W-1:0] cfg;
      input [31:0] stat;
      input [CFG_W-1:0] ser;
      begin
         case (addr)
            `TMC_OFS_CONFIG: read_mux = {{(32-CFG_W){1'b0}}, cfg};
            `TMC_OFS_STATUS: read_mux = stat;
            `TMC_OFS_SERIAL: read_mux = {{(32-CFG_W){1'b0}}, ser};
            default: read_mux = 32'h00000000;
         endcase
      end
   endfunction

   // True for an offset that exists
   function mapped;
      input [3:0] addr;
      begin
         mapped = (addr == `TMC_OFS_CONFIG) || (addr == `TMC_OFS_STATUS) ||
                  (addr == `TMC_OFS_SERIAL);
      end
   endfunction

   // ==================================================
   // Pin synchronisers, bit 2 tx data, bit 1 crystal, bit 0 rx request
   assign pagree = p2 ~^ p3;
   assign next_pfilt = (pagree & p3) | (~pagree & pfilt);
   assign rx_req = pfilt[0];
   assign tx_bit = pfilt[2];
   assign ref_rise = next_pfilt[1] & ~pfilt[1];

   // Three stages, a change is taken once stages two and three agree
   always @(posedge aclk) begin
      if (!aresetn) begin
         p1 <= 3'h0;
         p2 <= 3'h0;
         p3 <= 3'h0;
         pfilt <= 3'h0;
      end else begin
         p1 <= {tx_data_pin, crystal_input_pin, rx_request_pin};
         p2 <= p1;
         p3 <= p2;
         pfilt <= next_pfilt;
      end
   end

   // ==================================================
   // Serial configuration receiver
   tmc_serial_rx #(
      .CFG_W(CFG_W)
   ) u_serial (
      .aclk(aclk),
      .aresetn(aresetn),
      .serial_enable_pin(serial_enable_pin),
      .serial_data_pin(serial_data_pin),
      .serial_clock_pin(serial_clock_pin),
      .word_valid(ser_valid),
      .word(ser_word),
      .frame_bad(ser_bad)
   );

   // ==================================================
   // AXI4-Lite write side
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready = !w_held && !s_axi_bvalid;
   assign do_write = aw_held && w_held && !s_axi_bvalid;

   // Address and data are held independently until both have arrived
   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 4'h0;
         w_data <= 32'h00000000;
         w_strb <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `TMC_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (do_write) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(aw_addr) ? `TMC_RESP_OKAY : `TMC_RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ==================================================
   // AXI4-Lite read side
   assign s_axi_arready = !s_axi_rvalid;

   // One read at a time, answered the cycle after the address is taken
   always @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `TMC_RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= read_mux(s_axi_araddr, settings, status_word, ser_word);
         s_axi_rresp <= mapped(s_axi_araddr) ? `TMC_RESP_OKAY : `TMC_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // Status view of the block's own state
   assign status_word = {22'h0, ser_bad, ref_present, osc_enable, bias_enable,
                         pll_enable, carrier_enable, tx_enable, rx_enable, state};

   // ==================================================
   // Configuration register
   // A serial frame wins over a bus write in the same cycle
   always @(posedge aclk) begin
      if (!aresetn) begin
         settings <= `TMC_CFG_RESET;
      end else if (ser_valid) begin
         settings <= ser_word;
      end else if (do_write && aw_addr == `TMC_OFS_CONFIG && w_strb[0]) begin
         settings <= w_data[CFG_W-1:0];
      end
   end

   // ==================================================
   // Operating state
   // Only the request pin and the transmit-select bit choose the state
   always @* begin
      case ({rx_req, settings[`TMC_CFG_TX_SELECT]})
         2'b00: next_state = `TMC_ST_STANDBY;
         2'b01: next_state = `TMC_ST_TRANSMIT;
         2'b10: next_state = `TMC_ST_RECEIVE;
         2'b11: next_state = `TMC_ST_CARRIER;
         default: next_state = `TMC_ST_STANDBY;
      endcase
   end

   // State is registered before any enable is decoded
   always @(posedge aclk) begin
      if (!aresetn) begin
         state <= `TMC_ST_STANDBY;
      end else begin
         state <= next_state;
      end
   end

   // ==================================================
   // Block enables, all from the registered state in one edge
   always @(posedge aclk) begin
      if (!aresetn) begin
         rx_enable <= 1'b0;
         tx_enable <= 1'b0;
         carrier_enable <= 1'b0;
         pll_enable <= 1'b0;
         bias_enable <= 1'b0;
      end else begin
         case (state)
            `TMC_ST_CARRIER: begin
               rx_enable <= 1'b0;
               tx_enable <= 1'b0;
               carrier_enable <= 1'b1;
               pll_enable <= 1'b0;
               bias_enable <= 1'b1;
            end
            `TMC_ST_TRANSMIT: begin
               rx_enable <= 1'b0;
               tx_enable <= 1'b1;
               carrier_enable <= 1'b0;
               pll_enable <= 1'b1;
               bias_enable <= 1'b1;
            end
            `TMC_ST_RECEIVE: begin
               rx_enable <= 1'b1;
               tx_enable <= 1'b0;
               carrier_enable <= 1'b0;
               pll_enable <= 1'b1;
               bias_enable <= 1'b1;
            end
            default: begin
               rx_enable <= 1'b0;
               tx_enable <= 1'b0;
               carrier_enable <= 1'b0;
               pll_enable <= 1'b0;
               bias_enable <= 1'b0;
            end
         endcase
      end
   end

   // ==================================================
   // Clock generator control
   // Oscillator follows its bit whatever the state
   always @(posedge aclk) begin
      if (!aresetn) begin
         osc_enable <= 1'b1;
         ext_clock_select <= 1'b0;
         pll_mult <= PLL_MULT_A;
         pa_level <= 3'h0;
      end else begin
         osc_enable <= settings[`TMC_CFG_CRYSTAL_RUN];
         ext_clock_select <= ~settings[`TMC_CFG_CRYSTAL_RUN];
         pll_mult <= settings[`TMC_CFG_PLL_SEL] ? PLL_MULT_B : PLL_MULT_A;
         pa_level <= settings[`TMC_CFG_PA_HI:`TMC_CFG_PA_LO];
      end
   end

   // Reference watchdog: no rising edge on the crystal input for too long means no reference
   always @(posedge aclk) begin
      if (!aresetn) begin
         ref_count <= 16'h0000;
         ref_present <= 1'b0;
      end else if (ref_rise) begin
         ref_count <= 16'h0000;
         ref_present <= 1'b1;
      end else if (ref_count >= `TMC_REF_LOSS_CYC) begin
         ref_present <= 1'b0;
      end else begin
         ref_count <= ref_count + 16'h0001;
      end
   end

   // ==================================================
   // FSK modulator
   // Accumulator never jumps, so a change of bit keeps phase continuous
   always @(posedge aclk) begin
      if (!aresetn) begin
         phase <= 32'h00000000;
         fsk_mark <= 1'b0;
         tx_wave <= 1'b0;
      end else if (tx_enable) begin
         fsk_mark <= tx_bit;
         phase <= phase + (tx_bit ? INC_MARK : INC_SPACE);
         tx_wave <= phase[31];
      end else begin
         fsk_mark <= 1'b0;
         tx_wave <= 1'b0;
      end
   end

endmodule

// *** tmc_map.vh ***
// Constants of the transceiver mode control: register offsets, field positions, reset values, timing counts.
// Assumes inclusion by bare name from the design files; definitions only.
//
// What this block does
// - In transmit a one goes out at carrier plus deviation and a zero at carrier minus deviation, phase continuous.
// - The operating state comes only from the receive-request pin and the transmit-select configuration bit.
// - Standby turns off receiver, transmitter, carrier detector, PLL and bias, leaving the logic and, if its bit is set, the oscillator running.
// - The crystal-run bit alone decides whether the oscillator runs, in every state including standby.
// - Carrier watch turns on only the carrier detector and bias; receiver, transmitter and PLL stay off.
// - Transmit turns on transmitter, PLL and bias, with receiver and carrier detector off.
// - Receive turns on receiver, PLL and bias, with transmitter and carrier detector off.
// - PLL is on only in transmit and receive, bias in every state but standby, logic always.
// - The PLL multiplication factor is chosen between exactly two configured values.
// - The PLL derives from a 32.768 kHz crystal reference.
// - The host loads configuration over a 3-wire serial bus, which the logic receives.
// - All block controls follow from the selected state and the current configuration contents.
`ifndef TMC_MAP_VH
`define TMC_MAP_VH

// ==================================================
// Register offsets
`define TMC_OFS_CONFIG 4'h0
`define TMC_OFS_STATUS 4'h4
`define TMC_OFS_SERIAL 4'h8

// ==================================================
// Configuration fields
`define TMC_CFG_TX_SELECT 0
`define TMC_CFG_CRYSTAL_RUN 1
`define TMC_CFG_PLL_SEL 2
`define TMC_CFG_PA_LO 3
`define TMC_CFG_PA_HI 5
`define TMC_CFG_RESET 8'h02

// ==================================================
// State codes, {rx request, tx select}
`define TMC_ST_STANDBY 2'h0
`define TMC_ST_TRANSMIT 2'h1
`define TMC_ST_RECEIVE 2'h2
`define TMC_ST_CARRIER 2'h3

// ==================================================
// Clock generator and modulator
`define TMC_REF_KHZ 32.768
`define TMC_PLL_MULT_A 5'h12
`define TMC_PLL_MULT_B 5'h16
`define TMC_INC_MARK 32'h00fdd583
`define TMC_INC_SPACE 32'h00e54c20

// ==================================================
// Timing
`define TMC_CLK_MHZ 10
`define TMC_REF_LOSS_US 100
`define TMC_REF_LOSS_CYC (`TMC_REF_LOSS_US * `TMC_CLK_MHZ)

// ==================================================
// Bus answers
`define TMC_RESP_OKAY 2'h0
`define TMC_RESP_SLVERR 2'h2

`endif

// *** tmc_serial_rx.v ***
// 3-wire configuration receiver: enable, data and clock pins from the host.
// Assumes all three pins are asynchronous to aclk and the serial clock is far slower than aclk.
`timescale 1ns/1ns
module tmc_serial_rx #(
   parameter CFG_W = 8
) (
   // Clock and reset
   input wire aclk,
   input wire aresetn,
   // Serial pins
   input wire serial_enable_pin,
   input wire serial_data_pin,
   input wire serial_clock_pin,
   // Received word
   output reg word_valid,
   output reg [CFG_W-1:0] word,
   output reg frame_bad
);

   // ==================================================
   // Pin synchronisers, bit 2 enable, bit 1 data, bit 0 clock
   reg [2:0] s1;
   reg [2:0] s2;
   reg [2:0] s3;
   reg [2:0] filt;
   reg [CFG_W-1:0] shift;
   reg [7:0] count;
   wire [2:0] agree;
   wire [2:0] next_filt;
   wire clk_rise;
   wire en_fall;

   assign agree = s2 ~^ s3;
   assign next_filt = (agree & s3) | (~agree & filt);
   assign clk_rise = next_filt[0] & ~filt[0];
   assign en_fall = ~next_filt[2] & filt[2];

   // Three stages, a change is taken once stages two and three agree
   always @(posedge aclk) begin
      if (!aresetn) begin
         s1 <= 3'h0;
         s2 <= 3'h0;
         s3 <= 3'h0;
         filt <= 3'h0;
      end else begin
         s1 <= {serial_enable_pin, serial_data_pin, serial_clock_pin};
         s2 <= s1;
         s3 <= s2;
         filt <= next_filt;
      end
   end

   // ==================================================
   // Framing
   // Data shifts in MSB first on clock rises while enable is high
   always @(posedge aclk) begin
      if (!aresetn) begin
         shift <= {CFG_W{1'b0}};
         count <= 8'h00;
         word <= {CFG_W{1'b0}};
         word_valid <= 1'b0;
         frame_bad <= 1'b0;
      end else begin
         word_valid <= 1'b0;
         if (filt[2] && clk_rise) begin
            shift <= {shift[CFG_W-2:0], next_filt[1]};
            if (count != 8'hff) begin
               count <= count + 8'h01;
            end
         end
         if (en_fall) begin
            count <= 8'h00;
            // Only a frame of exactly one word is loaded
            if (count == CFG_W[7:0]) begin
               word <= shift;
               word_valid <= 1'b1;
               frame_bad <= 1'b0;
            end else begin
               frame_bad <= 1'b1;
            end
         end
      end
   end

endmodule

// *** tmc_mode_ctrl_monitor.sv ***
// Checker of the mode control: state decode, block enables, clock control, FSK mark.
// Assumes binding into tmc_mode_ctrl; sees only its ports.
`timescale 1ns/1ns
`include "tmc_map.vh"
module tmc_mode_ctrl_mon #(
   parameter [4:0] PLL_MULT_A = `TMC_PLL_MULT_A,
   parameter [4:0] PLL_MULT_B = `TMC_PLL_MULT_B
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Pins
   input wire logic rx_request_pin,
   input wire logic tx_data_pin,
   // Observed outputs
   input wire logic rx_enable,
   input wire logic tx_enable,
   input wire logic carrier_enable,
   input wire logic pll_enable,
   input wire logic bias_enable,
   input wire logic osc_enable,
   input wire logic ext_clock_select,
   input wire logic [4:0] pll_mult,
   input wire logic fsk_mark,
   input wire logic tx_wave,
   input wire logic [1:0] state
);
   // ==================================================
   // Enables decode from the state held one edge earlier
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   a_standby_dark: assert property (state == `TMC_ST_STANDBY
      |=> !(rx_enable | tx_enable | carrier_enable | pll_enable | bias_enable)) else $error("standby block on");
   a_carrier_only: assert property (state == `TMC_ST_CARRIER
      |=> carrier_enable && bias_enable && !rx_enable && !tx_enable && !pll_enable) else $error("carrier watch");
   a_transmit_set: assert property (state == `TMC_ST_TRANSMIT
      |=> tx_enable && pll_enable && bias_enable && !rx_enable && !carrier_enable) else $error("transmit set");
   a_receive_set: assert property (state == `TMC_ST_RECEIVE
      |=> rx_enable && pll_enable && bias_enable && !tx_enable && !carrier_enable) else $error("receive set");
   a_pll_use: assert property (pll_enable |-> rx_enable || tx_enable) else $error("pll on idle");
   a_bias_use: assert property (bias_enable == (rx_enable | tx_enable | carrier_enable))
      else $error("bias mismatch");
   // Oscillator and external clock select are exact opposites
   a_osc_pair: assert property (osc_enable != ext_clock_select) else $error("osc select");
   a_mult_two: assert property (pll_mult == PLL_MULT_A || pll_mult == PLL_MULT_B)
      else $error("pll factor");
   // A steady pin must be reflected in the state
   a_pin_decides: assert property ((aresetn && $stable(rx_request_pin))[*8]
      |-> state[1] == rx_request_pin) else $error("pin not in state");
   a_mark_follow: assert property ((tx_enable && $stable(tx_data_pin))[*6]
      |-> fsk_mark == tx_data_pin) else $error("fsk mark");
   a_tx_quiet: assert property (!tx_enable ##1 !tx_enable |-> !fsk_mark && !tx_wave)
      else $error("modulator active");
endmodule

bind tmc_mode_ctrl tmc_mode_ctrl_mon #(.PLL_MULT_A(PLL_MULT_A), .PLL_MULT_B(PLL_MULT_B)) tmc_mode_ctrl_mon_inst (
   .aclk, .aresetn, .rx_request_pin, .tx_data_pin, .rx_enable, .tx_enable, .carrier_enable, .pll_enable,
   .bias_enable, .osc_enable, .ext_clock_select, .pll_mult, .fsk_mark, .tx_wave, .state);

// *** tmc_host_model.sv ***
// Host model on the 3-wire configuration bus.
// Assumes the caller spaces frames; the link clock stands still low between them.
`timescale 1ns/1ns
module tmc_host_model (
   // Serial pins
   output logic serial_enable_pin,
   output logic serial_data_pin,
   output logic serial_clock_pin
);
   // ==================================================
   // Idle levels
   initial begin
      serial_enable_pin = 1'b0;
      serial_data_pin = 1'b0;
      serial_clock_pin = 1'b0;
   end
   // Frame of nbits, MSB first, 800 ns link clock period
   task send(input logic [7:0] w, input int nbits);
      int i;
      #37 serial_enable_pin = 1'b1;
      for (i = 0; i < nbits; i++) begin
         serial_data_pin = w[7-i];
         #400 serial_clock_pin = 1'b1;
         #400 serial_clock_pin = 1'b0;
      end
      #400 serial_enable_pin = 1'b0;
      // Data line is released: show the inverse, not the last bit
      serial_data_pin = ~serial_data_pin;
   endtask
endmodule

// *** tb.sv ***
// Testbench of the mode control: AXI4-Lite master, pins, crystal and host model.
// Assumes tmc_mode_ctrl with default parameters and the bound checker.
`timescale 1ns/1ns
`include "tmc_map.vh"
module tb;
   logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, rx_request_pin, crystal_input_pin;
   logic tx_data_pin, serial_enable_pin, serial_data_pin, serial_clock_pin, rx_enable, tx_enable;
   logic carrier_enable, pll_enable, bias_enable, osc_enable, ext_clock_select, ref_present, fsk_mark, tx_wave;
   logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [1:0] s_axi_bresp, s_axi_rresp, state, r, mode;
   logic [4:0] pll_mult, e;
   logic [2:0] pa_level;
   logic [7:0] cfg;
   logic txb;
   int failures = 0, num_checks = 0, k, seed;
   tmc_mode_ctrl tmc_mode_ctrl_inst (.*);
   tmc_host_model tmc_host_model_inst (.serial_enable_pin, .serial_data_pin, .serial_clock_pin);
   // ==================================================
   // Clocks: 100 ns system, 32.768 kHz crystal
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end
   initial begin
      crystal_input_pin = 1'b0;
      forever #15259 crystal_input_pin = ~crystal_input_pin;
   end
   // Compare and verdict
   task chk(input string n, input logic [31:0] exp, input logic [31:0] got);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("Error %s expected %h seen %h", n, exp, got);
      end
   endtask
   task give_verdict;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   initial begin
      #2000000;
      failures++;
      give_verdict;
   end
   // AXI master: ready sampled at the falling edge, acted on at the next rising edge
   task axi_wr(input logic [3:0] a, input logic [31:0] wd, output logic [1:0] resp);
      int n;
      logic done, ah, wh;
      s_axi_awaddr <= a;
      s_axi_wdata <= wd;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      done = 1'b0;
      for (n = 0; n < 100 && !done; n++) begin
         @(negedge aclk);
         ah = s_axi_awvalid && s_axi_awready;
         wh = s_axi_wvalid && s_axi_wready;
         done = s_axi_bvalid;
         resp = s_axi_bresp;
         @(posedge aclk);
         if (ah) s_axi_awvalid <= 1'b0;
         if (wh) s_axi_wvalid <= 1'b0;
         if (done) s_axi_bready <= 1'b0;
      end
      if (!done) failures++;
   endtask
   task axi_rd(input logic [3:0] a, output logic [31:0] rd, output logic [1:0] resp);
      int n;
      logic done, ah;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      done = 1'b0;
      for (n = 0; n < 100 && !done; n++) begin
         @(negedge aclk);
         ah = s_axi_arvalid && s_axi_arready;
         done = s_axi_rvalid;
         rd = s_axi_rdata;
         resp = s_axi_rresp;
         @(posedge aclk);
         if (ah) s_axi_arvalid <= 1'b0;
         if (done) s_axi_rready <= 1'b0;
      end
      if (!done) failures++;
   endtask
   // Expected enables {rx, tx, carrier, pll, bias} per {rx request, tx select}
   function logic [4:0] exp_en(input logic [1:0] m);
      case (m)
         2'h1: exp_en = 5'b01011;
         2'h2: exp_en = 5'b10011;
         2'h3: exp_en = 5'b00101;
         default: exp_en = 5'b00000;
      endcase
   endfunction
   // ==================================================
   // Main sequence
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
      {rx_request_pin, tx_data_pin, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 0;
      s_axi_wstrb = 4'hf;
      seed = $urandom(32607);
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      axi_rd(`TMC_OFS_CONFIG, d, r);
      chk("config reset", 32'h02, d);
      chk("osc reset", 1, osc_enable);
      // Every mode first, then random ones
      for (k = 0; k < 14; k++) begin
         mode = (k < 4) ? k[1:0] : 2'($urandom % 4);
         cfg = {2'h0, 6'($urandom)};
         cfg[0] = mode[0];
         txb = 1'($urandom);
         rx_request_pin <= mode[1];
         tx_data_pin <= txb;
         axi_wr(`TMC_OFS_CONFIG, {24'h0, cfg}, r);
         chk("write resp", `TMC_RESP_OKAY, r);
         repeat (12) @(posedge aclk);
         e = exp_en(mode);
         chk("state", mode, state);
         chk("enables", e, {rx_enable, tx_enable, carrier_enable, pll_enable, bias_enable});
         chk("osc", {cfg[1], ~cfg[1]}, {osc_enable, ext_clock_select});
         chk("pll mult", cfg[2] ? `TMC_PLL_MULT_B : `TMC_PLL_MULT_A, pll_mult);
         chk("pa level", cfg[5:3], pa_level);
         chk("fsk mark", (mode == 2'h1) ? txb : 1'b0, fsk_mark);
         axi_rd(`TMC_OFS_STATUS, d, r);
         chk("status", {cfg[1], e[0], e[1], e[2], e[3], e[4], mode}, d[7:0]);
      end
      // Unmapped place refused without effect
      axi_wr(4'hc, 32'h0, r);
      chk("unmapped wr", `TMC_RESP_SLVERR, r);
      axi_rd(4'hc, d, r);
      chk("unmapped rresp", `TMC_RESP_SLVERR, r);
      chk("unmapped rdata", 32'h0, d);
      // Serial load, then a short frame that must be refused
      rx_request_pin <= 1'b0;
      tmc_host_model_inst.send(8'h05, 8);
      repeat (20) @(posedge aclk);
      axi_rd(`TMC_OFS_CONFIG, d, r);
      chk("serial config", 32'h05, d);
      chk("serial state", `TMC_ST_TRANSMIT, state);
      chk("ext clock", 1, ext_clock_select);
      @(posedge aclk);
      axi_rd(`TMC_OFS_SERIAL, d, r);
      chk("serial word", 32'h05, d);
      tmc_host_model_inst.send(8'h02, 7);
      repeat (20) @(posedge aclk);
      axi_rd(`TMC_OFS_CONFIG, d, r);
      chk("short frame", 32'h05, d);
      @(posedge aclk);
      axi_rd(`TMC_OFS_STATUS, d, r);
      chk("frame bad", 1, d[9]);
      chk("reference", 1, ref_present);
      give_verdict;
   end
endmodule
